// >>> line_status_unit.sv
`timescale 1ns/1ns
`default_nettype none
`include "line_status_params.svh"

// Overview of operation
// - parity mismatch sets parity error flag
// - fifo mode reports parity of head character
// - character arriving while full sets overrun
// - overrun character never pushed into store
// - data ready while any character held
// - four change flags track modem inputs
// - modem status read clears change flags
// - bit 7 carrier, loop-back user_output_two
// - bit 6 ring, loop-back user_output_one
// - bit 5 dsr, loop-back dtr
// - bit 4 cts, loop-back rts
// - auto cts halts after current character
// - carrier toggle sets bit 3, interrupt
// - ring 0-to-1 input sets bit 2, interrupt
// - dsr toggle bit 1, cts toggle bit 0
// - any change flag raises modem interrupt
module line_status_unit #(
  parameter int DEPTH = 64
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rx_char_done,
  input wire logic [7:0] rx_char,
  input wire logic rx_par_bit,
  input wire logic rx_pop,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ri_n,
  input wire logic dcd_n,
  input wire logic tx_busy,
  output logic rx_ready,
  output logic [7:0] rx_head,
  output logic tx_halt,
  output logic modem_irq,
  output logic dtr_n,
  output logic rts_n
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] CAP_FIFO = (AW+1)'(DEPTH);
  localparam logic [AW:0] CAP_HOLD = (AW+1)'(1);

  // ========================================================
  // bus slave: address phase decode, zero wait states
  line_status_pkg::reg_sel_e sel;
  line_status_pkg::reg_sel_e wsel_q, wsel_d;
  logic ap_take, rd_take, wr_pend_q, wr_pend_d;
  logic ls_rd, ms_rd;
  logic [31:0] hrdata_q, hrdata_d;
  line_status_pkg::byte_t rd_val;

  always_comb begin
    case (haddr[7:0])
      `OFS_LINE_STATUS: sel = line_status_pkg::SEL_LS;
      `OFS_MODEM_STATUS: sel = line_status_pkg::SEL_MS;
      `OFS_MODEM_CONTROL: sel = line_status_pkg::SEL_MC;
      `OFS_LINE_CONTROL: sel = line_status_pkg::SEL_LC;
      `OFS_FIFO_CONTROL: sel = line_status_pkg::SEL_FC;
      `OFS_FEATURE_CONTROL: sel = line_status_pkg::SEL_FE;
      default: sel = line_status_pkg::SEL_NONE;
    endcase
  end

  assign ap_take = hsel && hready && htrans[1];
  assign rd_take = ap_take && !hwrite;
  assign ls_rd = rd_take && (sel == line_status_pkg::SEL_LS);
  assign ms_rd = rd_take && (sel == line_status_pkg::SEL_MS);

  always_comb begin
    wr_pend_d = ap_take && hwrite;
    wsel_d = sel;
    hrdata_d = hrdata_q;
    if (rd_take) begin
      hrdata_d = {24'h000000, rd_val};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wsel_q <= line_status_pkg::SEL_NONE;
      hrdata_q <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      wr_pend_q <= wr_pend_d;
      wsel_q <= wsel_d;
      hrdata_q <= hrdata_d;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign hrdata = hrdata_q;

  // ========================================================
  // software control registers, written in the data phase
  logic [`MC_WIDTH-1:0] mc_q, mc_d;
  logic [`LC_WIDTH-1:0] lc_q, lc_d;
  logic fifo_en_q, fifo_en_d, auto_cts_q, auto_cts_d, flush;

  always_comb begin
    mc_d = mc_q;
    lc_d = lc_q;
    fifo_en_d = fifo_en_q;
    auto_cts_d = auto_cts_q;
    if (wr_pend_q) begin
      case (wsel_q)
        line_status_pkg::SEL_MC: mc_d = hwdata[`MC_WIDTH-1:0];
        line_status_pkg::SEL_LC: lc_d = hwdata[`LC_WIDTH-1:0];
        line_status_pkg::SEL_FC: fifo_en_d = hwdata[`FC_ENABLE];
        line_status_pkg::SEL_FE: auto_cts_d = hwdata[`FE_AUTO_CTS];
        default: mc_d = mc_q;
      endcase
    end
  end

  // a mode switch empties the store; old entries mean nothing
  assign flush = fifo_en_d != fifo_en_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mc_q <= `RST_MODEM_CONTROL;
      lc_q <= `RST_LINE_CONTROL;
      fifo_en_q <= 1'b0;
      auto_cts_q <= 1'b0;
    end else begin
      mc_q <= mc_d;
      lc_q <= lc_d;
      fifo_en_q <= fifo_en_d;
      auto_cts_q <= auto_cts_d;
    end
  end

  // ========================================================
  // receive store: one character when not in fifo mode
  rx_store_if #(.AW(AW), .DW(9)) store ();

  rx_store_mem #(.AW(AW), .DW(9)) u_store (
    .hclk(hclk),
    .hresetn(hresetn),
    .port(store)
  );

  logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [AW:0] count_q, count_d;
  logic full, push, pop, perr, ovr_q, ovr_d, rx_ready_q;
  logic [7:0] masked;

  // unused upper bits of short characters are not in parity
  always_comb begin
    masked = rx_char;
    case (lc_q[`LC_WLEN_LO +: 2])
      2'h0: masked = {3'h0, rx_char[4:0]};
      2'h1: masked = {2'h0, rx_char[5:0]};
      2'h2: masked = {1'h0, rx_char[6:0]};
      default: masked = rx_char;
    endcase
  end

  assign perr = lc_q[`LC_PEN] &&
    (rx_par_bit != (lc_q[`LC_EVEN] ? ^masked : ~^masked));
  assign full = count_q >= (fifo_en_q ? CAP_FIFO : CAP_HOLD);
  assign push = rx_char_done && !full;
  assign pop = rx_pop && (count_q != '0);

  always_comb begin
    wr_ptr_d = wr_ptr_q + AW'(push);
    rd_ptr_d = rd_ptr_q + AW'(pop);
    count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) begin
      wr_ptr_d = '0;
      rd_ptr_d = '0;
      count_d = '0;
    end
    // overrun sticky, set beats read clear
    ovr_d = (ovr_q && !ls_rd) || (rx_char_done && full);
  end

  assign store.wr_en = push;
  assign store.wr_addr = wr_ptr_q;
  assign store.wr_data = {perr, rx_char};
  assign store.rd_addr = rd_ptr_d;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      ovr_q <= 1'b0;
      rx_ready_q <= 1'b0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
      ovr_q <= ovr_d;
      rx_ready_q <= count_d != '0;
    end
  end

  assign rx_ready = rx_ready_q;
  assign rx_head = store.rd_data[7:0];

  // ========================================================
  // modem inputs: two-stage synchronisers
  logic [3:0] s1_q, s2_q, live, prev_q, delta_q, delta_d, dset;
  logic [1:0] arm_q, arm_d;
  logic irq_q, halt_q, halt_d, dtr_n_q, rts_n_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= `RST_SYNC;
      s2_q <= `RST_SYNC;
    end else begin
      s1_q <= {dcd_n, ri_n, dsr_n, cts_n};
      s2_q <= s1_q;
    end
  end

  // live levels in modem_status order: dcd, ri, dsr, cts
  always_comb begin
    live = ~s2_q;
    if (mc_q[`MC_LOOP]) begin
      live[3] = mc_q[`MC_USER_OUTPUT_TWO];
      live[2] = mc_q[`MC_USER_OUTPUT_ONE];
      live[1] = mc_q[`MC_DTR];
      live[0] = mc_q[`MC_RTS];
    end
  end

  always_comb begin
    dset[3] = live[3] ^ prev_q[3];
    // ring pin 0-to-1 is status bit falling
    dset[2] = prev_q[2] && !live[2];
    dset[1] = live[1] ^ prev_q[1];
    dset[0] = live[0] ^ prev_q[0];
    // ignore the settling of the synchronisers after reset
    if (arm_q != `ARM_DONE) begin
      dset = 4'h0;
    end
    delta_d = (delta_q & ~{4{ms_rd}}) | dset;
    arm_d = (arm_q == `ARM_DONE) ? arm_q : arm_q + 2'h1;
    halt_d = auto_cts_q && !live[0] && (halt_q || !tx_busy);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_q <= 4'h0;
      delta_q <= 4'h0;
      arm_q <= 2'h0;
      irq_q <= 1'b0;
      halt_q <= 1'b0;
      dtr_n_q <= 1'b1;
      rts_n_q <= 1'b1;
    end else begin
      prev_q <= live;
      delta_q <= delta_d;
      arm_q <= arm_d;
      irq_q <= |delta_d;
      halt_q <= halt_d;
      dtr_n_q <= !mc_q[`MC_DTR] || mc_q[`MC_LOOP];
      rts_n_q <= !mc_q[`MC_RTS] || mc_q[`MC_LOOP];
    end
  end

  assign modem_irq = irq_q;
  assign tx_halt = halt_q;
  assign dtr_n = dtr_n_q;
  assign rts_n = rts_n_q;

  // ========================================================
  // read multiplexer
  always_comb begin
    case (sel)
      line_status_pkg::SEL_LS: rd_val = {5'h00,
        store.rd_data[8] && rx_ready_q, ovr_q, rx_ready_q};
      line_status_pkg::SEL_MS: rd_val = {live, delta_q};
      line_status_pkg::SEL_MC: rd_val = {3'h0, mc_q};
      line_status_pkg::SEL_LC: rd_val = {3'h0, lc_q};
      line_status_pkg::SEL_FC: rd_val = {7'h00, fifo_en_q};
      line_status_pkg::SEL_FE: rd_val = {auto_cts_q, 7'h00};
      default: rd_val = 8'h00;
    endcase
  end

  // ========================================================
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_ovr_on_full: assert property (
    rx_char_done && full |=> ovr_q)
    else $error("overrun not flagged on full store");
  a_full_no_push: assert property (
    rx_char_done && full && !rx_pop && !flush |=> count_q == $past(count_q))
    else $error("character pushed into full store");
  a_ready_push: assert property (
    push && !flush |=> rx_ready ##0 count_q != '0)
    else $error("data ready missing after push");
  a_ms_clear: assert property (
    ms_rd && dset == 4'h0 |=> delta_q == 4'h0)
    else $error("modem status read left a change flag");
  a_dcd_toggle: assert property (
    arm_q == `ARM_DONE && live[3] != prev_q[3] |=> delta_q[3] && modem_irq)
    else $error("carrier change not flagged");
  a_ri_lead_edge: assert property (
    arm_q == `ARM_DONE && !prev_q[2] && live[2] && !delta_q[2]
    |=> !delta_q[2])
    else $error("ring flag set on wrong edge");
  a_irq_tracks: assert property (
    delta_q != 4'h0 |-> modem_irq ##1 (delta_q == 4'h0 || modem_irq))
    else $error("modem interrupt not raised");
  a_halt_wait: assert property (
    tx_busy && !halt_q |=> !halt_q)
    else $error("transmission halted mid character");
  a_halt_set: assert property (
    auto_cts_q && !live[0] && !tx_busy |=> halt_q)
    else $error("auto cts did not halt transmitter");
  a_loop_cts: assert property (
    ms_rd |=> hrdata[`MS_CTS] == $past(live[0]) ##0
      ($past(mc_q[`MC_LOOP]) ? $past(mc_q[`MC_RTS]) : !$past(s2_q[0]))
      == hrdata[`MS_CTS])
    else $error("cts status bit wrong");
  a_par_head: assert property (
    ls_rd |=> hrdata[`LS_PARITY] == $past(store.rd_data[8] && rx_ready_q))
    else $error("parity flag not from head entry");

endmodule : line_status_unit

`default_nettype wire

// >>> line_status_params.svh
`ifndef LINE_STATUS_PARAMS_SVH
`define LINE_STATUS_PARAMS_SVH

// ==========================================================
// register byte offsets
`define OFS_LINE_STATUS 8'h00
`define OFS_MODEM_STATUS 8'h04
`define OFS_MODEM_CONTROL 8'h08
`define OFS_LINE_CONTROL 8'h0C
`define OFS_FIFO_CONTROL 8'h10
`define OFS_FEATURE_CONTROL 8'h14

// ==========================================================
// line_status fields
`define LS_READY 0
`define LS_OVERRUN 1
`define LS_PARITY 2

// ==========================================================
// modem_status fields: deltas in 3:0, live levels in 7:4
`define MS_DCTS 0
`define MS_DDSR 1
`define MS_TERI 2
`define MS_DDCD 3
`define MS_CTS 4
`define MS_DSR 5
`define MS_RI 6
`define MS_DCD 7

// ==========================================================
// modem_control, line_control, fifo and feature fields
`define MC_DTR 0
`define MC_RTS 1
`define MC_USER_OUTPUT_ONE 2
`define MC_USER_OUTPUT_TWO 3
`define MC_LOOP 4
`define MC_WIDTH 5
`define LC_WLEN_LO 0
`define LC_PEN 3
`define LC_EVEN 4
`define LC_WIDTH 5
`define FC_ENABLE 0
`define FE_AUTO_CTS 7

// ==========================================================
// reset values and the end count of the arm counter
`define RST_MODEM_CONTROL 5'h00
`define RST_LINE_CONTROL 5'h00
`define RST_SYNC 4'hF
`define ARM_DONE 2'h3

`endif

// >>> line_status_pkg.sv
package line_status_pkg;

  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_LS = 3'b001,
    SEL_MS = 3'b010,
    SEL_MC = 3'b011,
    SEL_LC = 3'b100,
    SEL_FC = 3'b101,
    SEL_FE = 3'b110
  } reg_sel_e;

  typedef logic [7:0] byte_t;

endpackage : line_status_pkg

// >>> rx_store_if.sv
`timescale 1ns/1ns
`default_nettype none

interface rx_store_if #(
  parameter int AW = 6,
  parameter int DW = 9
);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;

  modport ctrl (
    output wr_en,
    output wr_addr,
    output wr_data,
    output rd_addr,
    input rd_data
  );

  modport mem (
    input wr_en,
    input wr_addr,
    input wr_data,
    input rd_addr,
    output rd_data
  );
endinterface : rx_store_if

`default_nettype wire

// >>> rx_store_mem.sv
`timescale 1ns/1ns
`default_nettype none

module rx_store_mem #(
  parameter int AW = 6,
  parameter int DW = 9
) (
  input wire logic hclk,
  input wire logic hresetn,
  rx_store_if.mem port
);

  logic [DW-1:0] mem_q [0:(1<<AW)-1];
  logic [DW-1:0] rd_d;
  logic [DW-1:0] rd_q;

  // write-through so a push into an empty store shows at once
  always_comb begin
    rd_d = mem_q[port.rd_addr];
    if (port.wr_en && (port.wr_addr == port.rd_addr)) begin
      rd_d = port.wr_data;
    end
  end

  always_ff @(posedge hclk) begin
    if (port.wr_en) begin
      mem_q[port.wr_addr] <= port.wr_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q <= '0;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign port.rd_data = rd_q;

endmodule : rx_store_mem

`default_nettype wire

// >>> modem_model.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// far-side modem: drives the four handshake pins
module modem_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0] want,
  output logic cts_n,
  output logic dsr_n,
  output logic ri_n,
  output logic dcd_n
);
  // pins move a few ns off the edge, unrelated to the bus
  // timing; the pull-ups hold them inactive high in reset
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {dcd_n, ri_n, dsr_n, cts_n} <= 4'hF;
    end else begin
      {dcd_n, ri_n, dsr_n, cts_n} <= #7 want;
    end
  end
endmodule : modem_model

`default_nettype wire

// >>> line_status_unit_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "line_status_params.svh"

module line_status_unit_tb;
  localparam int DEPTH = 4;
  localparam logic [7:0] LOOP_BIT [4] = '{8'h20, 8'h10, 8'h40, 8'h80};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic rx_char_done = 1'b0;
  logic [7:0] rx_char = 8'h00;
  logic rx_par_bit = 1'b0;
  logic rx_pop = 1'b0;
  logic tx_busy = 1'b0;
  logic [3:0] want = 4'hF;
  logic cts_n, dsr_n, ri_n, dcd_n;
  logic rx_ready, tx_halt, modem_irq, dtr_n, rts_n;
  logic [7:0] rx_head;
  logic [31:0] rd;
  logic [7:0] lv;
  logic [7:0] dl;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;

  always #10 hclk = ~hclk;

  line_status_unit #(.DEPTH(DEPTH)) i_line_status_unit (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rx_char_done(rx_char_done), .rx_char(rx_char),
    .rx_par_bit(rx_par_bit), .rx_pop(rx_pop), .cts_n(cts_n),
    .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n), .tx_busy(tx_busy),
    .rx_ready(rx_ready), .rx_head(rx_head), .tx_halt(tx_halt),
    .modem_irq(modem_irq), .dtr_n(dtr_n), .rts_n(rts_n)
  );

  modem_model i_modem_model (
    .hclk(hclk), .hresetn(hresetn), .want(want), .cts_n(cts_n),
    .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n)
  );

  // ==========================================================
  // verdict and hang guard
  task report_and_stop;
    if (err_total == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 6000) begin
      err_total++;
      report_and_stop();
    end
  end

  // ==========================================================
  // access tasks
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // ends just past an edge so registered outputs have landed
  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : idle

  // hsel stays high, so only htrans marks a transfer
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] wd);
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus

  // idle after a write: dtr_n and rts_n follow the register an edge later
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
    idle(1);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                     input string what);
    bus(a, 1'b0, 32'h0);
    chk(what, exp, rd);
  endtask : rdc

  task automatic push(input logic [7:0] c, input logic p);
    rx_char_done <= 1'b1;
    rx_char <= c;
    rx_par_bit <= p;
    @(posedge hclk);
    rx_char_done <= 1'b0;
    idle(1);
  endtask : push

  task automatic pop;
    rx_pop <= 1'b1;
    @(posedge hclk);
    rx_pop <= 1'b0;
    idle(1);
  endtask : pop

  // ==========================================================
  // test sequence
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    idle(4);
    chk("dtr_n", 32'h1, {31'h0, dtr_n});
    chk("rts_n", 32'h1, {31'h0, rts_n});
    chk("hresp", 32'h0, {31'h0, hresp});
    chk("rx_ready", 32'h0, {31'h0, rx_ready});
    chk("modem_irq", 32'h0, {31'h0, modem_irq});
    rdc(`OFS_LINE_STATUS, 32'h0, "line_status");
    rdc(`OFS_MODEM_STATUS, 32'h0, "modem_status");
    rdc(8'h18, 32'h0, "unmapped");
    // each pin falls in turn; the ring flag waits for a rise
    lv = 8'h00;
    for (int i = 0; i < 4; i++) begin
      want[i] <= 1'b0;
      lv[i+4] = 1'b1;
      dl = (i == 2) ? 8'h00 : 8'h01 << i;
      idle(5);
      chk("modem_irq", {31'h0, i != 2}, {31'h0, modem_irq});
      rdc(`OFS_MODEM_STATUS, {24'h0, lv | dl}, "modem_status");
      rdc(`OFS_MODEM_STATUS, {24'h0, lv}, "modem_status");
      idle(1);
      chk("modem_irq", 32'h0, {31'h0, modem_irq});
    end
    want <= 4'hF;
    idle(5);
    rdc(`OFS_MODEM_STATUS, 32'h0F, "modem_status");
    // loop-back: one control bit at a time onto the live bits
    for (int j = 0; j < 4; j++) begin
      wr(`OFS_MODEM_CONTROL, 32'h10 | (32'h1 << j));
      idle(4);
      bus(`OFS_MODEM_STATUS, 1'b0, 32'h0);
      chk("loop_live", {24'h0, LOOP_BIT[j]}, rd & 32'hF0);
    end
    wr(`OFS_MODEM_CONTROL, 32'h13);
    chk("dtr_n", 32'h1, {31'h0, dtr_n});
    chk("rts_n", 32'h1, {31'h0, rts_n});
    wr(`OFS_MODEM_CONTROL, 32'h03);
    rdc(`OFS_MODEM_CONTROL, 32'h03, "modem_control");
    chk("dtr_n", 32'h0, {31'h0, dtr_n});
    chk("rts_n", 32'h0, {31'h0, rts_n});
    idle(4);
    rdc(`OFS_MODEM_STATUS, 32'h0B, "modem_status");
    // receive: 8 bits, even parity, single holding register
    wr(`OFS_LINE_CONTROL, 32'h1B);
    push(8'h55, 1'b0);
    chk("rx_ready", 32'h1, {31'h0, rx_ready});
    chk("rx_head", 32'h55, {24'h0, rx_head});
    push(8'hA3, ^8'hA3);
    rdc(`OFS_LINE_STATUS, 32'h03, "line_status");
    chk("rx_head", 32'h55, {24'h0, rx_head});
    rdc(`OFS_LINE_STATUS, 32'h01, "line_status");
    pop();
    chk("rx_ready", 32'h0, {31'h0, rx_ready});
    push(8'h55, 1'b1);
    rdc(`OFS_LINE_STATUS, 32'h05, "line_status");
    pop();
    rdc(`OFS_LINE_STATUS, 32'h00, "line_status");
    // fifo mode: parity follows the head entry
    wr(`OFS_FIFO_CONTROL, 32'h01);
    push(8'h0F, 1'b1);
    push(8'h33, 1'b0);
    rdc(`OFS_LINE_STATUS, 32'h05, "line_status");
    pop();
    rdc(`OFS_LINE_STATUS, 32'h01, "line_status");
    chk("rx_head", 32'h33, {24'h0, rx_head});
    pop();
    for (int k = 0; k < DEPTH; k++) push(8'h10 + k[7:0], ^(8'h10 + k[7:0]));
    push(8'hEE, ^8'hEE);
    rdc(`OFS_LINE_STATUS, 32'h03, "line_status");
    for (int k = 0; k < DEPTH; k++) begin
      chk("rx_head", 32'h10 + k, {24'h0, rx_head});
      pop();
    end
    chk("rx_ready", 32'h0, {31'h0, rx_ready});
    // 5 bits, odd parity: upper bits stay out of the check
    wr(`OFS_LINE_CONTROL, 32'h08);
    push(8'hE1, 1'b0);
    push(8'h03, 1'b0);
    rdc(`OFS_LINE_STATUS, 32'h01, "line_status");
    pop();
    rdc(`OFS_LINE_STATUS, 32'h05, "line_status");
    pop();
    // auto flow control: a busy character finishes first
    // busy goes up before enable, else the halt comes at once
    tx_busy <= 1'b1;
    wr(`OFS_FEATURE_CONTROL, 32'h80);
    idle(3);
    chk("tx_halt", 32'h0, {31'h0, tx_halt});
    tx_busy <= 1'b0;
    idle(2);
    chk("tx_halt", 32'h1, {31'h0, tx_halt});
    want[0] <= 1'b0;
    idle(5);
    chk("tx_halt", 32'h0, {31'h0, tx_halt});
    want[0] <= 1'b1;
    idle(5);
    chk("tx_halt", 32'h1, {31'h0, tx_halt});
    wr(`OFS_FEATURE_CONTROL, 32'h00);
    idle(1);
    chk("tx_halt", 32'h0, {31'h0, tx_halt});
    report_and_stop();
  end
endmodule : line_status_unit_tb

`default_nettype wire
